// >>> nfh_pkg.sv
`default_nettype none
package nfh_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // command codes and id address
   localparam logic [7:0] CMD_READ       = 8'h00;
   localparam logic [7:0] CMD_READ_SPARE = 8'h50;
   localparam logic [7:0] CMD_READ_ID    = 8'h90;
   localparam logic [7:0] CMD_STATUS     = 8'h70;
   localparam logic [7:0] CMD_RESET      = 8'hFF;
   localparam logic [7:0] ID_ADDR        = 8'h00;
   // timing figures as printed (ns)
   localparam int T_WB_NS   = 100;
   localparam int T_RR_NS   = 20;
   localparam int T_CEH_NS  = 100;
   localparam int T_AR_NS   = 100;
   localparam int T_ALRE_NS = 50;
   localparam int T_WHR_NS  = 60;
   localparam int T_PULSE_NS = 40;
   // cycle counts: least times round up; then array geometry
   localparam int T_WB_CYC   = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_RR_CYC   = (T_RR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_CEH_CYC  = (T_CEH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_AR_CYC   = (T_AR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_ALRE_CYC = (T_ALRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_WHR_CYC  = (T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_PULSE_CYC = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NUM_BLOCKS = 1024;
   localparam int PAGE_BYTES = 528;
   localparam int ID_BYTES   = 2;
   // host request kinds
   typedef enum logic [2:0] {
      NFH_OP_CMD,
      NFH_OP_ADDR,
      NFH_OP_DATA_WR,
      NFH_OP_READ,
      NFH_OP_WAIT_READY,
      NFH_OP_ABORT
   } nfh_op_type;
endpackage
`default_nettype wire

// >>> nfh_skid.sv
`timescale 1ns/10ps
`default_nettype none
module nfh_skid
   import nfh_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   if (DEPTH != 2) begin : g_bad_depth
      $error("nfh_skid supports depth 2 only");
   end
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic                        wr;
      logic                        rd;
      logic [1:0]                  cnt;
      logic [WIDTH-1:0]            head;
      logic                        vld;
   } nfh_skid_type;
   nfh_skid_type s, next_s;
   logic push, pop;
   assign push = in_valid_i && (s.cnt != 2'd2);
   assign pop  = (s.cnt != 2'd0) && out_ready_i;
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = in_data_i;
         next_s.wr = ~s.wr;
      end
      if (pop) begin
         next_s.rd = ~s.rd;
      end
      next_s.cnt = 2'(s.cnt + {1'b0, push} - {1'b0, pop});
      // head and valid kept in flops so the read outputs need no logic after them
      next_s.vld = (next_s.cnt != 2'd0);
      next_s.head = next_s.mem[next_s.rd];
   end
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign in_ready_o  = (s.cnt != 2'd2);
   assign out_valid_o = s.vld;
   assign out_data_o  = s.head;
endmodule
`default_nettype wire

// >>> nfh_host.sv
// How it works
// R1 - device loads page, busy up to 7 us
// R2 - reset returns device idle within limits
// R3 - busy falls within 100 ns of strobe
// R4 - busy after last read strobe of page
// R5 - wait 20 ns after ready before reading
// R6 - chip select high 100 ns aborts latency
// R7 - spare-area select low during 50h latch
// R8 - only reset and status during busy
// R9 - each read strobe gives next byte
// R10 - id: 90h, 00h, two read strobes
// R11 - first read 100/50 ns after address latch
// R12 - all 1024 blocks valid, no remap
// R13 - latch command or address on rising strobe
// R14 - write inhibit low blocks program/erase
`timescale 1ns/10ps
`default_nettype none
module nfh_host
   import nfh_pkg::*;
#(
   parameter int WAIT_LIMIT = 8191
) (
   input  wire logic       ref_clk_i,
   input  wire logic       rst_i,
   input  wire logic       req_valid_i,
   input  wire nfh_op_type req_op_i,
   input  wire logic [7:0] req_data_i,
   input  wire logic       req_id_i,
   input  wire logic       req_wp_n_i,
   output logic            req_ready_o,
   output logic            req_refused_o,
   output logic            timeout_o,
   output logic [7:0]      rd_data_o,
   output logic            rd_valid_o,
   input  wire logic       rd_ready_i,
   output logic            chip_enable_n_o,
   output logic            cmd_latch_o,
   output logic            addr_latch_o,
   output logic            write_strobe_n_o,
   output logic            read_strobe_n_o,
   output logic            spare_area_select_n_o,
   output logic            write_inhibit_n_o,
   output logic [7:0]      io_o,
   output logic            io_oe_o,
   input  wire logic [7:0] io_i,
   input  wire logic       ready_busy_n_i
);
   if (WAIT_LIMIT < 64 || WAIT_LIMIT > 65535) begin : g_bad_limit
      $error("WAIT_LIMIT out of range");
   end
   typedef enum logic [2:0] {
      ST_IDLE, ST_WR_LOW, ST_WR_HIGH, ST_RD_LOW, ST_RD_HIGH, ST_WAIT, ST_ABORT
   } nfh_state_type;
   typedef struct packed {
      nfh_state_type state;
      logic [15:0]   cnt;
      logic [15:0]   gap;
      logic          busy_seen;
      logic          ce_n;
      logic          cle;
      logic          ale;
      logic          we_n;
      logic          rstb_n;
      logic          spare_n;
      logic          wp_n;
      logic [7:0]    io;
      logic          oe;
      logic          ready;
      logic          refused;
      logic          timeout;
      logic          addr_was_id;
      logic          push;
      logic [7:0]    push_data;
   } nfh_reg_type;
   nfh_reg_type r, next_r;
   logic [1:0] rb_sync;
   logic [7:0] io_s1, io_s2;
   logic       buf_ready;
   logic       rb;
   assign rb = rb_sync[1];
   // pins pass two flops before use
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rb_sync <= 2'b11;
         io_s1   <= 8'h00;
         io_s2   <= 8'h00;
      end else begin
         rb_sync <= {rb_sync[0], ready_busy_n_i};
         io_s1   <= io_i;
         io_s2   <= io_s1;
      end
   end
   function automatic logic allowed_busy(input logic [7:0] c);
      return (c == CMD_RESET) || (c == CMD_STATUS);
   endfunction
   always_comb begin
      next_r = r;
      next_r.push = 1'b0;
      next_r.refused = 1'b0;
      next_r.timeout = 1'b0;
      next_r.ready = 1'b0;
      next_r.cnt = 16'(r.cnt + 16'd1);
      if (r.gap != 16'd0) next_r.gap = 16'(r.gap - 16'd1);
      case (r.state)
         ST_IDLE: begin
            // all requests wait out the gap and a full buffer; simpler than per-op ready
            next_r.ready = (next_r.gap == 16'd0) && buf_ready;
            next_r.cnt = 16'd0;
            if (r.ready && req_valid_i) begin
               next_r.ready = 1'b0;
               next_r.wp_n = req_wp_n_i; // see R14
               case (req_op_i)
                  NFH_OP_CMD, NFH_OP_ADDR, NFH_OP_DATA_WR: begin
                     if (!rb && !(req_op_i == NFH_OP_CMD && allowed_busy(req_data_i))) begin
                        next_r.refused = 1'b1; // see R8
                        next_r.ready = 1'b1;
                     end else begin
                        next_r.state = ST_WR_LOW;
                        next_r.ce_n = 1'b0;
                        next_r.we_n = 1'b0;
                        next_r.cle = (req_op_i == NFH_OP_CMD); // see R13
                        next_r.ale = (req_op_i == NFH_OP_ADDR); // see R13
                        next_r.spare_n = !(req_op_i == NFH_OP_CMD &&
                                           req_data_i == CMD_READ_SPARE); // see R7
                        next_r.io = req_data_i;
                        next_r.oe = 1'b1;
                        next_r.addr_was_id = req_id_i; // see R10
                     end
                  end
                  NFH_OP_READ: begin
                     if (!rb) begin
                        next_r.refused = 1'b1; // see R8
                        next_r.ready = 1'b1;
                     end else begin
                        next_r.state = ST_RD_LOW; // see R9
                        next_r.ce_n = 1'b0;
                        next_r.cle = 1'b0;
                        next_r.ale = 1'b0;
                        next_r.rstb_n = 1'b0;
                        next_r.oe = 1'b0;
                     end
                  end
                  NFH_OP_WAIT_READY: begin
                     next_r.state = ST_WAIT;
                     next_r.busy_seen = 1'b0;
                  end
                  default: begin
                     next_r.state = ST_ABORT; // see R6
                     next_r.ce_n = 1'b1;
                  end
               endcase
            end
         end
         ST_WR_LOW: begin
            if (r.cnt >= 16'(T_PULSE_CYC - 1)) begin
               next_r.we_n = 1'b1; // see R13
               next_r.state = ST_WR_HIGH;
               next_r.cnt = 16'd0;
            end
         end
         ST_WR_HIGH: begin
            if (r.cnt >= 16'(T_PULSE_CYC - 1)) begin
               next_r.oe = 1'b0;
               // hold off reads: id 100 ns, data 50 ns, and 60 ns after strobe
               if (r.ale) begin
                  next_r.gap = r.addr_was_id ? 16'(T_AR_CYC) : 16'(T_WHR_CYC); // see R11
               end else begin
                  next_r.gap = 16'(T_WHR_CYC);
               end
               if (r.ale && !r.addr_was_id && T_ALRE_CYC > T_WHR_CYC) begin
                  next_r.gap = 16'(T_ALRE_CYC); // see R11
               end
               // wait past the busy window so a launched operation is seen
               next_r.gap = (next_r.gap > 16'(T_WB_CYC)) ? next_r.gap : 16'(T_WB_CYC); // see R3
               next_r.cle = 1'b0;
               next_r.ale = 1'b0;
               next_r.spare_n = 1'b1;
               next_r.state = ST_IDLE;
            end
         end
         ST_RD_LOW: begin
            if (r.cnt >= 16'(T_PULSE_CYC - 1)) begin
               next_r.rstb_n = 1'b1;
               next_r.push = 1'b1; // see R9
               next_r.push_data = io_s2;
               next_r.state = ST_RD_HIGH;
               next_r.cnt = 16'd0;
            end
         end
         ST_RD_HIGH: begin
            if (r.cnt >= 16'(T_PULSE_CYC - 1)) begin
               // page boundary may raise busy again
               next_r.gap = 16'(T_WB_CYC); // see R4
               next_r.state = ST_IDLE;
            end
         end
         ST_WAIT: begin
            if (!rb) next_r.busy_seen = 1'b1; // see R1
            if (rb && (r.busy_seen || r.cnt > 16'(T_WB_CYC))) begin
               next_r.gap = 16'(T_RR_CYC + 2); // see R5
               next_r.state = ST_IDLE;
            end else if (r.cnt >= 16'(WAIT_LIMIT)) begin
               next_r.timeout = 1'b1; // see R2
               next_r.state = ST_IDLE;
            end
         end
         ST_ABORT: begin
            if (r.cnt >= 16'(T_CEH_CYC)) begin
               next_r.ce_n = 1'b0; // see R6
               next_r.gap = 16'(T_RR_CYC + 2);
               next_r.state = ST_IDLE;
            end
         end
         default: next_r.state = ST_IDLE;
      endcase
   end
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         r <= '{state: ST_IDLE, cnt: 16'h0000, gap: 16'h0000, ce_n: 1'b1,
                we_n: 1'b1, rstb_n: 1'b1, spare_n: 1'b1, io: 8'h00, push_data: 8'h00,
                default: 1'b0};
      end else begin
         r <= next_r;
      end
   end
   nfh_skid #(
      .WIDTH (8),
      .DEPTH (2)
   ) u_buf (
      .ref_clk_i   (ref_clk_i),
      .rst_i       (rst_i),
      .in_data_i   (r.push_data),
      .in_valid_i  (r.push),
      .in_ready_o  (buf_ready),
      .out_data_o  (rd_data_o),
      .out_valid_o (rd_valid_o),
      .out_ready_i (rd_ready_i)
   );
   assign req_ready_o           = r.ready;
   assign req_refused_o         = r.refused;
   assign timeout_o             = r.timeout;
   assign chip_enable_n_o       = r.ce_n;
   assign cmd_latch_o           = r.cle;
   assign addr_latch_o          = r.ale;
   assign write_strobe_n_o      = r.we_n;
   assign read_strobe_n_o       = r.rstb_n;
   assign spare_area_select_n_o = r.spare_n;
   assign write_inhibit_n_o     = r.wp_n;
   assign io_o                  = r.io;
   assign io_oe_o               = r.oe;
endmodule
`default_nettype wire

// >>> nfh_host_sva.sv
`timescale 1ns/10ps
`default_nettype none
module nfh_host_sva
   import nfh_pkg::*;
(
   input wire logic       ref_clk_i,
   input wire logic       rst_i,
   input wire logic       req_valid_i,
   input wire nfh_op_type req_op_i,
   input wire logic [7:0] req_data_i,
   input wire logic       req_id_i,
   input wire logic       req_wp_n_i,
   input wire logic       req_ready_o,
   input wire logic       req_refused_o,
   input wire logic       timeout_o,
   input wire logic [7:0] rd_data_o,
   input wire logic       rd_valid_o,
   input wire logic       rd_ready_i,
   input wire logic       chip_enable_n_o,
   input wire logic       cmd_latch_o,
   input wire logic       addr_latch_o,
   input wire logic       write_strobe_n_o,
   input wire logic       read_strobe_n_o,
   input wire logic       spare_area_select_n_o,
   input wire logic       write_inhibit_n_o,
   input wire logic [7:0] io_o,
   input wire logic       io_oe_o,
   input wire logic [7:0] io_i,
   input wire logic       ready_busy_n_i
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   logic take;
   assign take = req_valid_i && req_ready_o;
   sequence s_we_pulse; (!write_strobe_n_o)[*4] ##1 write_strobe_n_o; endsequence
   sequence s_rd_pulse; (!read_strobe_n_o)[*4] ##1 read_strobe_n_o; endsequence
   sequence s_ce_hold; chip_enable_n_o[*8] ##1 chip_enable_n_o[*2]; endsequence
   property p_we; $fell(write_strobe_n_o) |-> s_we_pulse; endproperty
   property p_rd_pulse; $fell(read_strobe_n_o) |-> s_rd_pulse ##1 rd_valid_o; endproperty
   property p_rr; $fell(read_strobe_n_o) |-> $past(ready_busy_n_i) && $past(ready_busy_n_i, 2);
   endproperty
   property p_alre; $fell(addr_latch_o) |-> read_strobe_n_o[*5]; endproperty
   property p_spare; !spare_area_select_n_o |-> cmd_latch_o && io_o == CMD_READ_SPARE; endproperty
   property p_abort; take && req_op_i == NFH_OP_ABORT |-> ##[1:2] s_ce_hold; endproperty
   property p_busy;
      take && req_op_i == NFH_OP_READ && !ready_busy_n_i && !$past(ready_busy_n_i)
         && !$past(ready_busy_n_i, 2) |-> ##1 req_refused_o;
   endproperty
   property p_rst_cmd;
      take && req_op_i == NFH_OP_CMD && req_data_i == CMD_RESET
         |-> ##1 !req_refused_o && !write_strobe_n_o && cmd_latch_o && io_o == CMD_RESET;
   endproperty
   a_we: assert property (p_we) else $error("write pulse width");
   a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse or byte");
   a_rr: assert property (p_rr) else $error("read too soon after ready");
   a_alre: assert property (p_alre) else $error("read too soon after address");
   a_spare: assert property (p_spare) else $error("spare select misplaced");
   a_abort: assert property (p_abort) else $error("abort hold short");
   a_busy: assert property (p_busy) else $error("read not refused");
   a_rst_cmd: assert property (p_rst_cmd) else $error("reset command lost");
   property p_bus_dir;
      !write_strobe_n_o || !read_strobe_n_o |-> io_oe_o == read_strobe_n_o && !chip_enable_n_o;
   endproperty
   a_bus_dir: assert property (p_bus_dir) else $error("bus direction wrong");
endmodule
`default_nettype wire

// >>> nfh_dev_model.sv
`timescale 1ns/10ps
`default_nettype none
module nfh_dev_model
   import nfh_pkg::*;
#(
   parameter int         T_R_NS   = 3000,
   parameter int         T_RST_NS = 200,
   parameter logic [7:0] MFR_CODE = 8'h5C,  // arbitrary
   parameter logic [7:0] DEV_CODE = 8'hB3   // arbitrary
) (
   input  wire logic       chip_enable_n_i,
   input  wire logic       cmd_latch_i,
   input  wire logic       addr_latch_i,
   input  wire logic       write_strobe_n_i,
   input  wire logic       read_strobe_n_i,
   input  wire logic [7:0] io_i,
   output logic [7:0]      io_o,
   output logic            ready_busy_n_o
);
   realtime    busy_until = 0;
   logic [7:0] cmd = CMD_READ;
   logic [7:0] dout = 8'h00;
   int         naddr = 0;
   int         idx = 0;
   // 5 ns poll keeps busy edges well inside 100 ns
   always #5 ready_busy_n_o = ($realtime >= busy_until);
   // released bus shows the inverse of the last byte
   assign io_o = read_strobe_n_i ? ~dout : dout;
   always @(posedge write_strobe_n_i) begin
      if (!chip_enable_n_i && cmd_latch_i) begin  // standby while deselected
         if (ready_busy_n_o || io_i == CMD_RESET || io_i == CMD_STATUS) begin
            cmd = io_i;
            naddr = 0;
            idx = 0;
         end
         if (io_i == CMD_RESET)
            busy_until = $realtime + T_RST_NS;
      end else if (!chip_enable_n_i && addr_latch_i && ready_busy_n_o) begin
         naddr++;  // any block accepted, none remapped
         if (cmd != CMD_READ_ID && naddr == 3)
            busy_until = $realtime + T_R_NS;
      end
   end
   always @(negedge read_strobe_n_i) begin
      if (!chip_enable_n_i && !cmd_latch_i && !addr_latch_i && write_strobe_n_i) begin
         dout = (cmd != CMD_READ_ID) ? (idx[7:0] ^ 8'h5A) : (idx == 0) ? MFR_CODE : DEV_CODE;
         idx++;
      end
   end
   // page end starts the next fetch
   always @(posedge read_strobe_n_i) begin
      if (!chip_enable_n_i && cmd != CMD_READ_ID && idx == PAGE_BYTES)
         busy_until = $realtime + T_R_NS;
   end
   always @(posedge chip_enable_n_i) begin
      #100;
      if (chip_enable_n_i)
         busy_until = $realtime;
   end
endmodule
`default_nettype wire

// >>> nfh_host_test.sv
`timescale 1ns/10ps
`default_nettype none
module nfh_host_test;
   import nfh_pkg::*;
   localparam logic [7:0] MFR = 8'h5C;  // arbitrary
   localparam logic [7:0] DEV = 8'hB3;  // arbitrary
   logic       ref_clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, req_id_i = 1'b0;
   logic       req_wp_n_i = 1'b1, rd_ready_i = 1'b1;
   nfh_op_type req_op_i = NFH_OP_CMD;
   logic [7:0] req_data_i = 8'h00, rd_data_o, io_o, dev_io, io_bus;
   logic       req_ready_o, req_refused_o, timeout_o, rd_valid_o, io_oe_o, ready_busy_n_i;
   logic       chip_enable_n_o, cmd_latch_o, addr_latch_o, write_strobe_n_o, read_strobe_n_o;
   logic       spare_area_select_n_o, write_inhibit_n_o;
   int         bad_count = 0, n_checks = 0, seed = 9375, lvl = 6;
   logic [7:0] exp_q[$];
   logic       ref_q[$];
   time        t0;
   assign io_bus = io_oe_o ? io_o : dev_io;
   always #5 ref_clk_i = ~ref_clk_i;
   nfh_host #(.WAIT_LIMIT(400)) i_dut (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
      .req_op_i(req_op_i), .req_data_i(req_data_i), .req_id_i(req_id_i),
      .req_wp_n_i(req_wp_n_i), .req_ready_o(req_ready_o), .req_refused_o(req_refused_o),
      .timeout_o(timeout_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
      .rd_ready_i(rd_ready_i), .chip_enable_n_o(chip_enable_n_o),
      .cmd_latch_o(cmd_latch_o), .addr_latch_o(addr_latch_o),
      .write_strobe_n_o(write_strobe_n_o), .read_strobe_n_o(read_strobe_n_o),
      .spare_area_select_n_o(spare_area_select_n_o),
      .write_inhibit_n_o(write_inhibit_n_o), .io_o(io_o), .io_oe_o(io_oe_o),
      .io_i(io_bus), .ready_busy_n_i(ready_busy_n_i));
   nfh_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_dev (.chip_enable_n_i(chip_enable_n_o),
      .cmd_latch_i(cmd_latch_o), .addr_latch_i(addr_latch_o), .write_strobe_n_i(write_strobe_n_o),
      .read_strobe_n_i(read_strobe_n_o), .io_i(io_bus), .io_o(dev_io),
      .ready_busy_n_o(ready_busy_n_i));
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_flag(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic req(input nfh_op_type op, input logic [7:0] d, input logic id);
      int n;
      n = 0;
      req_op_i = op;
      req_data_i = d;
      req_id_i = id;
      req_wp_n_i = 1'($random(seed));
      req_valid_i = 1'b1;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (req_ready_o !== 1'b1 && n < 2000);
      if (req_ready_o !== 1'b1) begin
         bad_count++;
         test_done;
      end else begin
         #1 check_flag(write_inhibit_n_o, req_wp_n_i);
         req_valid_i = 1'b0;
         @(posedge ref_clk_i);
         #1;
      end
   endtask
   task automatic rd(input logic [7:0] e);
      exp_q.push_back(e);
      req(NFH_OP_READ, 8'h00, 1'b0);
   endtask
   task automatic test_done;
      $display("checks=%0d errors=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      if (!rst_i && rd_valid_o === 1'b1 && rd_ready_i === 1'b1)
         check_byte(rd_data_o, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
      if (!rst_i && req_refused_o === 1'b1)
         check_flag(1'b1, (ref_q.size() > 0) ? ref_q.pop_front() : 1'b0);
      if (!rst_i && timeout_o !== 1'b0)
         check_flag(timeout_o, 1'b0);
      rd_ready_i <= #1 (($random(seed) & 7) < lvl);
   end
   initial begin
      repeat (2) @(posedge ref_clk_i);
      #1 rst_i = 1'b0;
      req(NFH_OP_CMD, CMD_READ_ID, 1'b0);
      req(NFH_OP_ADDR, ID_ADDR, 1'b1);
      rd(MFR);
      rd(DEV);
      req(NFH_OP_DATA_WR, 8'($random(seed)), 1'b0);
      // first pass starves the consumer so the buffer backs up
      for (int k = 0; k < 2; k++) begin
         lvl = k ? 6 : 1;
         req(NFH_OP_CMD, k ? CMD_READ_SPARE : CMD_READ, 1'b0);
         repeat (3) req(NFH_OP_ADDR, 8'($random(seed)), 1'b0);
         req(NFH_OP_WAIT_READY, 8'h00, 1'b0);
         for (int i = 0; i < 6; i++) rd(8'(i) ^ 8'h5A);
      end
      req(NFH_OP_CMD, CMD_READ, 1'b0);
      repeat (3) req(NFH_OP_ADDR, 8'h00, 1'b0);
      ref_q.push_back(1'b1);
      req(NFH_OP_READ, 8'h00, 1'b0);
      req(NFH_OP_CMD, CMD_STATUS, 1'b0);
      req(NFH_OP_CMD, CMD_RESET, 1'b0);
      req(NFH_OP_WAIT_READY, 8'h00, 1'b0);
      req(NFH_OP_CMD, CMD_READ, 1'b0);
      repeat (3) req(NFH_OP_ADDR, 8'h00, 1'b0);
      t0 = $time;
      req(NFH_OP_ABORT, 8'h00, 1'b0);
      req(NFH_OP_WAIT_READY, 8'h00, 1'b0);
      req(NFH_OP_CMD, CMD_STATUS, 1'b0);
      check_flag(($time - t0) < 1500, 1'b1);
      repeat (20) @(posedge ref_clk_i);
      check_flag(exp_q.size() == 0 && ref_q.size() == 0, 1'b1);
      test_done;
   end
   initial begin
      #200000;
      bad_count++;
      test_done;
   end
endmodule
bind nfh_host nfh_host_sva i_sva (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
   .req_op_i(req_op_i), .req_data_i(req_data_i), .req_id_i(req_id_i),
   .req_wp_n_i(req_wp_n_i), .req_ready_o(req_ready_o), .req_refused_o(req_refused_o),
   .timeout_o(timeout_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
   .rd_ready_i(rd_ready_i), .chip_enable_n_o(chip_enable_n_o),
   .cmd_latch_o(cmd_latch_o), .addr_latch_o(addr_latch_o),
   .write_strobe_n_o(write_strobe_n_o), .read_strobe_n_o(read_strobe_n_o),
   .spare_area_select_n_o(spare_area_select_n_o),
   .write_inhibit_n_o(write_inhibit_n_o), .io_o(io_o), .io_oe_o(io_oe_o),
   .io_i(io_i), .ready_busy_n_i(ready_busy_n_i));
`default_nettype wire
